// >>> rtl/bhs_defs.svh
`ifndef BHS_DEFS_SVH
`define BHS_DEFS_SVH
`define BHS_ADDR_W      23
`define BHS_DATA_W      16
`define BHS_ADDR_IDLE   23'h7FFFFF
`define BHS_DIV_RST     1'h0
`endif

// >>> rtl/bhs_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "bhs_defs.svh"
module bhs_device
  import bhs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  bhs_link_if.dev          link,
  input  wire logic        sleepEnableBit,
  input  wire logic        grantInvalidateBit,
  input  wire logic        cycleActive,
  input  wire logic        lockedRun,
  input  wire logic        pipeDrained,
  input  wire logic        haltExec,
  input  wire logic        irqEnable,
  input  wire logic        cacheMiss,
  output logic             coreRun,
  output logic             cacheInvalidate,
  output logic             nmiService,
  output logic             irqService,
  output logic             fetchResume,
  output logic             sleeping
);
  bhs_state_e stateQ;
  bhs_state_e stateD;
  logic       haltSleepQ;
  logic       nmiPendQ;
  logic       irqLatchQ;
  logic       busReqQ;
  logic       sleepReqNQ;
  logic       fltNQ;
  logic       nmiRise;
  logic       busFree;
  logic       sleepAsk;
  logic       wakeHalt;

  bhs_in_sync uSync (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .busReq       (link.busReq),
    .sleepReqN    (link.sleepReqN),
    .tristateAllN (link.tristateAllN),
    .nmi          (link.nmi),
    .busReqQ      (busReqQ),
    .sleepReqNQ   (sleepReqNQ),
    .tristateAllNQ(fltNQ),
    .nmiRise      (nmiRise)
  );

  assign busFree  = ~cycleActive & ~lockedRun;
  assign sleepAsk = sleepEnableBit & ~sleepReqNQ;
  assign wakeHalt = nmiRise | nmiPendQ
                  | (link.maskableIrq & irqEnable);

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      BHS_RUN: begin
        if (busReqQ) begin
          stateD = BHS_DRAIN;
        end else if (sleepAsk || (haltExec && sleepEnableBit)) begin
          stateD = BHS_SDRAIN;
        end
      end
      BHS_DRAIN: begin
        if (!busReqQ) begin
          stateD = BHS_RUN;
        end else if (busFree) begin
          stateD = BHS_GRANT;
        end
      end
      BHS_GRANT: begin
        if (!busReqQ) begin
          stateD = BHS_RUN;
        end
      end
      BHS_SDRAIN: begin
        if (busReqQ && busFree) begin
          stateD = BHS_DRAIN;
        end else if (!haltSleepQ && !sleepAsk) begin
          stateD = BHS_RUN;
        end else if (busFree && pipeDrained && link.coproBusyN) begin
          stateD = BHS_SLEEP;
        end
      end
      BHS_SLEEP: begin
        if (busReqQ) begin
          stateD = BHS_DRAIN;
        end else if (haltSleepQ ? wakeHalt : sleepReqNQ) begin
          stateD = BHS_RUN;
        end
      end
      default: stateD = BHS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stateQ <= BHS_RUN;
    end else begin
      stateQ <= stateD;
    end
  end

  // Sleep origin, stored NMI edge, latched irq
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      haltSleepQ <= 1'b0;
      nmiPendQ   <= 1'b0;
      irqLatchQ  <= 1'b0;
    end else begin
      if (stateQ == BHS_RUN && stateD == BHS_SDRAIN) begin
        haltSleepQ <= ~sleepAsk;
      end
      if (stateQ == BHS_GRANT && nmiRise) begin
        nmiPendQ <= 1'b1;
      end else if (stateQ == BHS_RUN) begin
        nmiPendQ <= 1'b0;
      end
      if (stateQ == BHS_SLEEP && !haltSleepQ && link.maskableIrq) begin
        irqLatchQ <= 1'b1;
      end else if (stateQ == BHS_RUN && irqEnable) begin
        irqLatchQ <= 1'b0;
      end
    end
  end

  // Service pulses, cache invalidate and core status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmiService      <= 1'b0;
      irqService      <= 1'b0;
      fetchResume     <= 1'b0;
      coreRun         <= 1'b1;
      cacheInvalidate <= 1'b0;
      sleeping        <= 1'b0;
    end else begin
      nmiService  <= (stateQ == BHS_GRANT && stateD == BHS_RUN
                     && nmiPendQ)
                   || (stateQ == BHS_SLEEP && haltSleepQ
                     && stateD == BHS_RUN && (nmiRise | nmiPendQ));
      irqService  <= stateQ == BHS_RUN && irqEnable
                   && (irqLatchQ | link.maskableIrq);
      fetchResume <= stateQ == BHS_SLEEP && stateD == BHS_RUN;
      coreRun     <= stateD != BHS_SLEEP
                   && !(stateD == BHS_GRANT && cacheMiss);
      cacheInvalidate <= stateQ == BHS_DRAIN && stateD == BHS_GRANT
                   && grantInvalidateBit;
      sleeping    <= stateD == BHS_SLEEP;
    end
  end

  logic granted;
  logic asleep;
  logic floatAll;
  assign granted  = stateQ == BHS_GRANT;
  assign asleep   = stateQ == BHS_SLEEP;
  assign floatAll = ~fltNQ;

  assign link.busGrantAck   = granted;
  assign link.busOe         = ~granted & ~floatAll;
  assign link.replOe        = ~granted & ~floatAll;
  assign link.dataOe        = ~granted & ~asleep & ~floatAll
                            & cycleActive & ~link.writeRdN ? 1'b0
                            : ~granted & ~asleep & ~floatAll
                            & cycleActive;
  assign link.sleepAckOe    = sleepEnableBit & ~floatAll;
  assign link.sleepAckN     = ~asleep;
  assign link.addr          = `BHS_ADDR_IDLE;
  assign link.addrStrobeN   = 1'b1;
  assign link.upperByteEnN  = ~cycleActive & ~asleep;
  assign link.lowerByteEnN  = ~cycleActive & ~asleep;
  assign link.dataCtlN      = 1'b1;
  assign link.lockN         = ~lockedRun;
  assign link.memIoN        = cycleActive;
  assign link.writeRdN      = 1'b0;
  assign link.dataOut       = {`BHS_DATA_W{1'b0}};
  assign link.replWay       = 1'b0;
  assign link.replWayValidN = 1'b1;
endmodule
`default_nettype wire

// >>> rtl/bhs_in_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bhs_in_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic busReq,
  input  wire logic sleepReqN,
  input  wire logic tristateAllN,
  input  wire logic nmi,
  output logic      busReqQ,
  output logic      sleepReqNQ,
  output logic      tristateAllNQ,
  output logic      nmiRise
);
  logic nmiQ;
  // Registered samples of the level inputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busReqQ       <= 1'b0;
      sleepReqNQ    <= 1'b1;
      tristateAllNQ <= 1'b1;
      nmiQ          <= 1'b0;
    end else begin
      busReqQ       <= busReq;
      sleepReqNQ    <= sleepReqN;
      tristateAllNQ <= tristateAllN;
      nmiQ          <= nmi;
    end
  end
  assign nmiRise = nmi & ~nmiQ;
endmodule
`default_nettype wire

// >>> rtl/bhs_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bhs_link_if;
  logic        busReq;
  logic        busGrantAck;
  logic        sleepReqN;
  logic        sleepAckN;
  logic        sleepAckOe;
  logic        tristateAllN;
  logic        nmi;
  logic        maskableIrq;
  logic        addrBit20MaskN;
  logic        coproXferReq;
  logic        coproBusyN;
  logic        cacheableN;
  logic        nextAddrReqN;
  logic        busReadyN;
  logic        flushN;
  logic [22:0] addr;
  logic        addrStrobeN;
  logic        upperByteEnN;
  logic        lowerByteEnN;
  logic        dataCtlN;
  logic        lockN;
  logic        memIoN;
  logic        writeRdN;
  logic        busOe;
  logic [15:0] dataOut;
  logic        dataOe;
  logic [15:0] dataIn;
  logic        replWay;
  logic        replWayValidN;
  logic        replOe;
  modport dev (
    input  busReq, sleepReqN, tristateAllN, nmi, maskableIrq,
    input  addrBit20MaskN, coproXferReq, coproBusyN, cacheableN,
    input  nextAddrReqN, busReadyN, flushN, dataIn,
    output busGrantAck, sleepAckN, sleepAckOe, addr, addrStrobeN,
    output upperByteEnN, lowerByteEnN, dataCtlN, lockN, memIoN,
    output writeRdN, busOe, dataOut, dataOe, replWay, replWayValidN,
    output replOe
  );
  modport sys (
    output busReq, sleepReqN, tristateAllN, nmi, maskableIrq,
    output addrBit20MaskN, coproXferReq, coproBusyN, cacheableN,
    output nextAddrReqN, busReadyN, flushN, dataIn,
    input  busGrantAck, sleepAckN, sleepAckOe, addr, addrStrobeN,
    input  upperByteEnN, lowerByteEnN, dataCtlN, lockN, memIoN,
    input  writeRdN, busOe, dataOut, dataOe, replWay, replWayValidN,
    input  replOe
  );
endinterface
`default_nettype wire

// >>> rtl/bhs_master.sv
`timescale 1ns/100ps
`default_nettype none
module bhs_master
  import bhs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  bhs_link_if.sys   link,
  input  wire logic wantBus,
  input  wire logic wantSleep,
  input  wire logic testFloat,
  input  wire logic nmiIn,
  input  wire logic irqIn,
  input  wire logic coproIdle,
  output logic      haveBus,
  output logic      isAsleep
);
  logic reqQ;
  logic sleepQ;
  logic fltQ;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reqQ     <= 1'b0;
      sleepQ   <= 1'b0;
      fltQ     <= 1'b0;
      haveBus  <= 1'b0;
      isAsleep <= 1'b0;
    end else begin
      reqQ     <= wantBus | (reqQ & ~link.busGrantAck & wantBus);
      sleepQ   <= wantSleep;
      fltQ     <= testFloat;
      haveBus  <= link.busGrantAck & reqQ;
      isAsleep <= link.sleepAckOe & ~link.sleepAckN;
    end
  end
  assign link.busReq         = reqQ;
  assign link.sleepReqN      = ~sleepQ;
  assign link.tristateAllN   = ~fltQ;
  assign link.nmi            = nmiIn;
  assign link.maskableIrq    = irqIn;
  assign link.addrBit20MaskN = 1'b1;
  assign link.coproXferReq   = 1'b0;
  assign link.coproBusyN     = coproIdle;
  assign link.cacheableN     = 1'b1;
  assign link.nextAddrReqN   = 1'b1;
  assign link.busReadyN      = 1'b0;
  assign link.flushN         = 1'b1;
  assign link.dataIn         = 16'h0000;
endmodule
`default_nettype wire

// >>> rtl/bhs_pkg.sv
package bhs_pkg;
  typedef enum logic [2:0] {
    BHS_RUN    = 3'b000,
    BHS_DRAIN  = 3'b001,
    BHS_GRANT  = 3'b011,
    BHS_SDRAIN = 3'b010,
    BHS_SLEEP  = 3'b110
  } bhs_state_e;
endpackage

// >>> verification/bhs_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module bhs_link_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        busReq,
  input wire logic        busGrantAck,
  input wire logic        sleepReqN,
  input wire logic        sleepAckN,
  input wire logic        sleepAckOe,
  input wire logic        tristateAllN,
  input wire logic        coproBusyN,
  input wire logic [22:0] addr,
  input wire logic        addrStrobeN,
  input wire logic        upperByteEnN,
  input wire logic        lowerByteEnN,
  input wire logic        dataCtlN,
  input wire logic        lockN,
  input wire logic        memIoN,
  input wire logic        writeRdN,
  input wire logic        busOe,
  input wire logic        dataOe,
  input wire logic        replOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire asleep = !sleepAckN && sleepAckOe;
  sequence floatHeld; !tristateAllN [*3]; endsequence
  sequence reqStays; busReq && $past(busReq); endsequence
  grant_float_a: assert property (
    busGrantAck |-> !busOe && !dataOe && !replOe) else $error("bus driven");
  grant_cause_a: assert property (
    busGrantAck |-> $past(busReq) || $past(busReq, 2)) else $error("no req");
  grant_hold_a: assert property (
    busGrantAck and reqStays |=> busGrantAck) else $error("grant lost");
  grant_release_a: assert property (
    $fell(busReq) |-> ##[1:3] !busGrantAck) else $error("grant kept");
  reset_idle_a: assert property (
    disable iff (1'b0) !rst_n |=> !busGrantAck) else $error("grant in reset");
  sleep_levels_a: assert property (
    asleep && busOe |-> addr == 23'h7FFFFF && addrStrobeN && dataCtlN
      && lockN && !upperByteEnN && !lowerByteEnN && !memIoN && !writeRdN
      && !dataOe) else $error("sleep levels");
  float_all_a: assert property (
    floatHeld |-> !busOe && !dataOe && !replOe && !sleepAckOe)
    else $error("pins not floated");
  sleep_resume_a: assert property (
    $rose(sleepReqN) && asleep |-> ##[1:4] sleepAckN) else $error("no wake");
  sleep_busy_a: assert property (
    $fell(sleepAckN) && !sleepReqN |-> $past(coproBusyN))
    else $error("slept while busy");
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  bad_count++; $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
  logic sys_clk = 1'h0;
  logic rst_n   = 1'h0;
  logic sleepEn = 1'h0, invBit = 1'h0, cycAct = 1'h0, drained = 1'h1;
  logic halt    = 1'h0, irqEn = 1'h0, wantBus = 1'h0, wantSleep = 1'h0;
  logic testFlt = 1'h0, nmiIn = 1'h0, irqIn = 1'h0, coproIdle = 1'h1;
  logic coreRun, cacheInv, nmiSvc, irqSvc, resume, sleeping, haveBus;
  logic locked = 1'h0, miss = 1'h0, asleepM;
  int   ep, flag, pulses, expInv;
  int   invQ[$];
  int   bad_count = 0;
  int   tests_run = 0;
  int   nmiCnt = 0, irqCnt = 0, resCnt = 0, invCnt = 0, expNmi = 0;
  bhs_link_if link ();
  bhs_device u_bhs_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .sleepEnableBit(sleepEn), .grantInvalidateBit(invBit),
    .cycleActive(cycAct), .lockedRun(locked), .pipeDrained(drained),
    .haltExec(halt), .irqEnable(irqEn), .cacheMiss(miss), .coreRun(coreRun),
    .cacheInvalidate(cacheInv), .nmiService(nmiSvc), .irqService(irqSvc),
    .fetchResume(resume), .sleeping(sleeping));
  bhs_master u_bhs_master (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .wantBus(wantBus), .wantSleep(wantSleep), .testFloat(testFlt),
    .nmiIn(nmiIn), .irqIn(irqIn), .coproIdle(coproIdle),
    .haveBus(haveBus), .isAsleep(asleepM));
  bhs_link_assertions u_bhs_link_assertions (.sys_clk(sys_clk),
    .rst_n(rst_n), .busReq(link.busReq), .busGrantAck(link.busGrantAck),
    .sleepReqN(link.sleepReqN), .sleepAckN(link.sleepAckN),
    .sleepAckOe(link.sleepAckOe), .tristateAllN(link.tristateAllN),
    .coproBusyN(link.coproBusyN), .addr(link.addr),
    .addrStrobeN(link.addrStrobeN), .upperByteEnN(link.upperByteEnN),
    .lowerByteEnN(link.lowerByteEnN), .dataCtlN(link.dataCtlN),
    .lockN(link.lockN), .memIoN(link.memIoN), .writeRdN(link.writeRdN),
    .busOe(link.busOe), .dataOe(link.dataOe), .replOe(link.replOe));
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (nmiSvc === 1'h1) nmiCnt++;
    if (irqSvc === 1'h1) irqCnt++;
    if (resume === 1'h1) resCnt++;
    if (cacheInv === 1'h1) invCnt++;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task waitGrant(input logic v);
    int i;
    for (i = 0; i < 30 && link.busGrantAck !== v; i++) tick(1);
  endtask
  task final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  initial begin
    void'($urandom(37451));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    invBit <= 1'h1;
    cycAct <= 1'h1;
    wantBus <= 1'h1;
    tick(6);
    `CHK(link.busGrantAck, 1'h0)
    @(posedge sys_clk) cycAct <= 1'h0;
    waitGrant(1'h1);
    tick(1);
    `CHK(haveBus, 1'h1)
    `CHK(link.busOe, 1'h0)
    `CHK(coreRun, 1'h1)
    @(posedge sys_clk) miss <= 1'h1;
    tick(2);
    `CHK(coreRun, 1'h0)
    @(posedge sys_clk) miss <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) nmiIn <= 1'h1;
      tick(3);
      @(posedge sys_clk) nmiIn <= 1'h0;
      tick(3);
      expNmi = 1;
    end
    tick(2 + $urandom % 8);
    `CHK(nmiCnt, 0)
    @(posedge sys_clk) wantBus <= 1'h0;
    waitGrant(1'h0);
    tick(4);
    `CHK(nmiCnt, expNmi)
    `CHK(link.busOe, 1'h1)
    `CHK(invCnt, 1)
    $display("Grant test done");
    @(posedge sys_clk);
    wantBus <= 1'h1;
    rst_n <= 1'h0;
    tick(5);
    `CHK(link.busGrantAck, 1'h0)
    @(posedge sys_clk);
    rst_n <= 1'h1;
    wantBus <= 1'h0;
    wantSleep <= 1'h1;
    coproIdle <= 1'h0;
    tick(8);
    `CHK(link.sleepAckOe, 1'h0)
    @(posedge sys_clk) sleepEn <= 1'h1;
    tick(8);
    `CHK(sleeping, 1'h0)
    @(posedge sys_clk) coproIdle <= 1'h1;
    tick(8);
    `CHK(link.sleepAckN, 1'h0)
    `CHK(asleepM, 1'h1)
    `CHK(coreRun, 1'h0)
    @(posedge sys_clk) wantBus <= 1'h1;
    waitGrant(1'h1);
    `CHK(link.busGrantAck, 1'h1)
    `CHK(link.sleepAckOe, 1'h1)
    @(posedge sys_clk) wantBus <= 1'h0;
    waitGrant(1'h0);
    `CHK(invCnt, 2)
    @(posedge sys_clk) wantSleep <= 1'h0;
    tick(8);
    `CHK(resCnt, 1)
    `CHK(sleeping, 1'h0)
    $display("Sleep test done");
    @(posedge sys_clk);
    irqEn <= 1'h1;
    halt <= 1'h1;
    tick(8);
    `CHK(link.sleepAckN, 1'h0)
    @(posedge sys_clk);
    irqIn <= 1'h1;
    halt <= 1'h0;
    tick(1);
    @(posedge sys_clk) irqIn <= 1'h0;
    tick(6);
    `CHK(irqCnt, 1)
    `CHK(sleeping, 1'h0)
    $display("Halt test done");
    expInv = 2;
    for (int r = 0; r < 12; r++) begin
      ep = $urandom % 3;
      flag = $urandom % 2;
      pulses = $urandom % 3;
      invQ.push_back(flag);
      @(posedge sys_clk);
      invBit  <= flag[0];
      cycAct  <= (ep == 1);
      locked  <= (ep == 2);
      wantBus <= 1'h1;
      tick(4 + $urandom % 4);
      `CHK(link.busGrantAck, (ep == 0))
      @(posedge sys_clk);
      cycAct <= 1'h0;
      locked <= 1'h0;
      waitGrant(1'h1);
      `CHK(link.busOe, 1'h0)
      repeat (pulses) begin
        @(posedge sys_clk) nmiIn <= 1'h1;
        tick(2);
        @(posedge sys_clk) nmiIn <= 1'h0;
        tick(2);
      end
      expNmi += (pulses != 0);
      @(posedge sys_clk) wantBus <= 1'h0;
      waitGrant(1'h0);
      tick(3);
      expInv += invQ.pop_front();
      `CHK(nmiCnt, expNmi)
      `CHK(invCnt, expInv)
    end
    $display("Random grant test done");
    @(posedge sys_clk) testFlt <= 1'h1;
    tick(6);
    `CHK(link.busOe, 1'h0)
    `CHK(link.dataOe, 1'h0)
    `CHK(link.sleepAckOe, 1'h0)
    @(posedge sys_clk);
    testFlt <= 1'h0;
    rst_n <= 1'h0;
    tick(3);
    @(posedge sys_clk) rst_n <= 1'h1;
    tick(3);
    `CHK(link.busGrantAck, 1'h0)
    $display("Float test done");
    final_report();
  end
endmodule
`default_nettype wire
